/* rtl/mfp_consts.vh */
/*
  Constants for the multi-function port control block: register indexes,
  field positions, reset values and timing figures.
  Assumes it is included by bare name from files under rtl/.
*/
`ifndef MFP_CONSTS_VH
`define MFP_CONSTS_VH

// ==========================================================
// Register indexes on the serial register port
`define REG_CONV_CTRL 5'h0b
`define REG_CONV_RESULT 5'h0c
`define REG_IRQ_MASK 5'h0d
`define REG_IRQ_REQUEST 5'h0e
`define REG_CMP_ENABLE 5'h0f
`define REG_CMP_INTERVAL 5'h10

// ==========================================================
// Converter control fields
`define CONV_OVF_BIT 5
`define CONV_RDY_BIT 4
`define CONV_LAUNCH_BIT 3
`define CONV_ON_BIT 2
`define CONV_SRC_HI 1
`define CONV_SRC_LO 0

// ==========================================================
// Interrupt request and mask fields
`define IRQ_UNDERVOLT_BIT 7
`define IRQ_UNKNOWN_CMD_BIT 6
`define IRQ_PARITY_BIT 5
`define IRQ_CONV_DONE_BIT 4
`define IRQ_CMP_HI 3
`define IRQ_CMP_LO 0

// ==========================================================
// Comparator enable register fields
`define CMP_ON_HI 3
`define CMP_ON_LO 0
`define CMP_DGL_HI 7
`define CMP_DGL_LO 4

// ==========================================================
// Reset values
`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_SRC 2'h0

// ==========================================================
// Timing
`define CLK_PERIOD_NS 100
`define FAST_SAMPLE_NS 1000
`define SLOW_BASE_MS 1
`define NS_PER_MS 1000000
`define DGL_SAMPLES 3'h4
`define DGL_CNT_W 3

`endif

/* rtl/cmp_channel.v */
/*
  One comparator channel: deglitch on four equal samples, edge detection
  in the chosen direction, and a trip flag held until the enable drops.
  Assumes the comparator input is already synchronised to mclk and that
  sample_tick is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfp_consts.vh"

module cmp_channel (
  input wire mclk,
  input wire rstn,
  input wire enable,
  input wire rising,
  input wire sample_tick,
  input wire cmp_level,
  output wire tripped
);

  reg stable_q, stable_d;
  reg known_q, known_d;
  reg [`DGL_CNT_W-1:0] count_q, count_d;
  reg trip_q, trip_d;

  // ==========================================================
  // Deglitch and edge detect
  always @* begin
    stable_d = stable_q;
    known_d = known_q;
    count_d = count_q;
    trip_d = trip_q;
    if (!enable) begin
      known_d = 1'b0;
      count_d = {`DGL_CNT_W{1'b0}};
      trip_d = 1'b0;
    end else if (sample_tick) begin
      if (!known_q) begin
        // First sample after arming sets the reference state
        stable_d = cmp_level;
        known_d = 1'b1;
      end else if (cmp_level == stable_q) begin
        count_d = {`DGL_CNT_W{1'b0}};
      end else if (count_q == `DGL_SAMPLES - 3'h1) begin
        stable_d = cmp_level;
        count_d = {`DGL_CNT_W{1'b0}};
        if (cmp_level == rising) begin
          trip_d = 1'b1;
        end
      end else begin
        count_d = count_q + 3'h1;
      end
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      stable_q <= 1'b0;
      known_q <= 1'b0;
      count_q <= {`DGL_CNT_W{1'b0}};
      trip_q <= 1'b0;
    end else begin
      stable_q <= stable_d;
      known_q <= known_d;
      count_q <= count_d;
      trip_q <= trip_d;
    end
  end

  assign tripped = trip_q;

endmodule

`default_nettype wire

/* rtl/mfp_ctrl.v */
/*
  Multi-function port control: single conversions, four deglitched edge
  comparators, interrupt request and mask with an active-low request pin.
  Assumes a serial link controller on mclk presents register accesses,
  a converter macro on mclk answers launches with a done pulse, and
  comparator and under-voltage levels arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfp_consts.vh"

module mfp_ctrl #(
  parameter integer SLOW_CYCLES = (`SLOW_BASE_MS * `NS_PER_MS) / `CLK_PERIOD_NS
) (
  input wire mclk,
  input wire rstn,
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output wire [7:0] reg_rdata,
  input wire [3:0] crossing_direction,
  input wire [3:0] multi_function_pin,
  input wire output_undervolt,
  input wire unknown_command,
  input wire link_parity_error,
  output wire converter_on,
  output wire [1:0] conv_source,
  output wire conv_launch,
  input wire conv_done,
  input wire conv_over_range,
  input wire [7:0] conv_data,
  output wire irq_n
);

  localparam integer FAST_CYCLES = `FAST_SAMPLE_NS / `CLK_PERIOD_NS;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_BUSY = 2'h1;

  // ==========================================================
  // Input synchronisers
  reg [3:0] pin_meta_q;
  reg [3:0] pin_sync_q;
  reg uv_meta_q;
  reg uv_sync_q;

  always @(posedge mclk) begin
    if (!rstn) begin
      pin_meta_q <= `RST_NIBBLE;
      pin_sync_q <= `RST_NIBBLE;
      uv_meta_q <= 1'b0;
      uv_sync_q <= 1'b0;
    end else begin
      pin_meta_q <= multi_function_pin;
      pin_sync_q <= pin_meta_q;
      uv_meta_q <= output_undervolt;
      uv_sync_q <= uv_meta_q;
    end
  end

  // ==========================================================
  // Registers written by software
  reg launch_q;
  reg conv_on_q;
  reg [1:0] src_q;
  reg [7:0] mask_q;
  reg [3:0] cmp_on_q;
  reg [3:0] cmp_dgl_q;
  reg [7:0] interval_q;

  wire wr_ctrl = reg_wr && (reg_addr == `REG_CONV_CTRL);
  wire wr_mask = reg_wr && (reg_addr == `REG_IRQ_MASK);
  wire wr_cmp = reg_wr && (reg_addr == `REG_CMP_ENABLE);
  wire wr_int = reg_wr && (reg_addr == `REG_CMP_INTERVAL);

  // Launch edge: start bit written 1 while it held 0
  wire launch_edge = wr_ctrl && reg_wdata[`CONV_LAUNCH_BIT] && !launch_q;

  always @(posedge mclk) begin
    if (!rstn) begin
      launch_q <= 1'b0;
      conv_on_q <= 1'b0;
      src_q <= `RST_SRC;
      mask_q <= `RST_BYTE;
      cmp_on_q <= `RST_NIBBLE;
      cmp_dgl_q <= `RST_NIBBLE;
      interval_q <= `RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        launch_q <= reg_wdata[`CONV_LAUNCH_BIT];
        conv_on_q <= reg_wdata[`CONV_ON_BIT];
        src_q <= reg_wdata[`CONV_SRC_HI:`CONV_SRC_LO];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata;
      end
      if (wr_cmp) begin
        cmp_on_q <= reg_wdata[`CMP_ON_HI:`CMP_ON_LO];
        cmp_dgl_q <= reg_wdata[`CMP_DGL_HI:`CMP_DGL_LO];
      end
      if (wr_int) begin
        interval_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Conversion sequencer
  reg [1:0] state_q, state_d;
  reg pulse_q, pulse_d;
  reg ovf_q, ovf_d;
  reg rdy_q, rdy_d;
  reg [7:0] result_q, result_d;
  reg done_evt;

  always @* begin
    state_d = state_q;
    pulse_d = 1'b0;
    ovf_d = ovf_q;
    rdy_d = rdy_q;
    result_d = result_q;
    done_evt = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // A write that also clears the enable launches nothing
        if (launch_edge && conv_on_q && reg_wdata[`CONV_ON_BIT]) begin
          pulse_d = 1'b1;
          ovf_d = 1'b0;
          rdy_d = 1'b0;
          state_d = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (!conv_on_q) begin
          state_d = ST_IDLE;
        end else if (conv_done) begin
          result_d = conv_data;
          ovf_d = conv_over_range;
          rdy_d = 1'b1;
          done_evt = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      pulse_q <= 1'b0;
      ovf_q <= 1'b0;
      rdy_q <= 1'b0;
      result_q <= `RST_BYTE;
    end else begin
      state_q <= state_d;
      pulse_q <= pulse_d;
      ovf_q <= ovf_d;
      rdy_q <= rdy_d;
      result_q <= result_d;
    end
  end

  // ==========================================================
  // Sample tick generation
  reg [15:0] fast_cnt_q;
  reg fast_tick_q;
  reg [31:0] slow_cnt_q;
  reg ms_tick_q;
  reg [2:0] ms_div_q;

  always @(posedge mclk) begin
    if (!rstn) begin
      fast_cnt_q <= 16'h0000;
      fast_tick_q <= 1'b0;
      slow_cnt_q <= 32'h00000000;
      ms_tick_q <= 1'b0;
      ms_div_q <= 3'h0;
    end else begin
      fast_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
      if (fast_cnt_q == FAST_CYCLES[15:0] - 16'h0001) begin
        fast_cnt_q <= 16'h0000;
        fast_tick_q <= 1'b1;
      end else begin
        fast_cnt_q <= fast_cnt_q + 16'h0001;
      end
      if (slow_cnt_q == SLOW_CYCLES[31:0] - 32'h00000001) begin
        slow_cnt_q <= 32'h00000000;
        ms_tick_q <= 1'b1;
      end else begin
        slow_cnt_q <= slow_cnt_q + 32'h00000001;
      end
      if (ms_tick_q) begin
        ms_div_q <= ms_div_q + 3'h1;
      end
    end
  end

  // Ticks every 1, 2, 4 and 8 ms
  wire [3:0] slow_tick;
  assign slow_tick[0] = ms_tick_q;
  assign slow_tick[1] = ms_tick_q && ms_div_q[0];
  assign slow_tick[2] = ms_tick_q && (ms_div_q[1:0] == 2'h3);
  assign slow_tick[3] = ms_tick_q && (ms_div_q == 3'h7);

  // ==========================================================
  // Comparator channels
  wire [3:0] trip;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
      wire [1:0] code = interval_q[2*gi+1:2*gi];
      wire tick = cmp_dgl_q[gi] ? slow_tick[code] : fast_tick_q;
      cmp_channel u_channel (
        .mclk(mclk),
        .rstn(rstn),
        .enable(cmp_on_q[gi]),
        .rising(crossing_direction[gi]),
        .sample_tick(tick),
        .cmp_level(pin_sync_q[gi]),
        .tripped(trip[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Interrupt request register
  reg [7:5] evt_q, evt_d;
  reg done_req_q, done_req_d;
  reg irq_n_q;

  wire rd_req = reg_rd && (reg_addr == `REG_IRQ_REQUEST);
  wire [7:0] request = {evt_q, done_req_q, trip};

  // Reading the request register clears bits 7 to 4 but not the trips; a new event wins
  always @* begin
    evt_d = evt_q;
    done_req_d = done_req_q;
    if (rd_req) begin
      evt_d = 3'h0;
      done_req_d = 1'b0;
    end
    if (uv_sync_q) begin
      evt_d[`IRQ_UNDERVOLT_BIT] = 1'b1;
    end
    if (unknown_command) begin
      evt_d[`IRQ_UNKNOWN_CMD_BIT] = 1'b1;
    end
    if (link_parity_error) begin
      evt_d[`IRQ_PARITY_BIT] = 1'b1;
    end
    if (done_evt) begin
      done_req_d = 1'b1;
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      evt_q <= 3'h0;
      done_req_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      evt_q <= evt_d;
      done_req_q <= done_req_d;
      irq_n_q <= ~|(request & mask_q);
    end
  end

  // ==========================================================
  // Register read
  reg [7:0] rdata_q;
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = `RST_BYTE;
    if (reg_addr == `REG_CONV_CTRL) begin
      rd_mux[`CONV_OVF_BIT] = ovf_q;
      rd_mux[`CONV_RDY_BIT] = rdy_q;
      rd_mux[`CONV_LAUNCH_BIT] = launch_q;
      rd_mux[`CONV_ON_BIT] = conv_on_q;
      rd_mux[`CONV_SRC_HI:`CONV_SRC_LO] = src_q;
    end else if (reg_addr == `REG_CONV_RESULT) begin
      rd_mux = result_q;
    end else if (reg_addr == `REG_IRQ_MASK) begin
      rd_mux = mask_q;
    end else if (reg_addr == `REG_IRQ_REQUEST) begin
      rd_mux = request;
    end else if (reg_addr == `REG_CMP_ENABLE) begin
      rd_mux = {cmp_dgl_q, cmp_on_q};
    end else if (reg_addr == `REG_CMP_INTERVAL) begin
      rd_mux = interval_q;
    end
  end

  always @(posedge mclk) begin
    if (!rstn) begin
      rdata_q <= `RST_BYTE;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata = rdata_q;
  assign converter_on = conv_on_q;
  assign conv_source = src_q;
  assign conv_launch = pulse_q;
  assign irq_n = irq_n_q;

endmodule

`default_nettype wire

/* tb/mfp_ctrl_checker.sv */
/*
  Port-level checker for the port control block, bound into mfp_ctrl.
  Assumes one clock domain and the register indexes of mfp_consts.vh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfp_consts.vh"
module mfp_ctrl_checker (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic converter_on,
  input wire logic [1:0] conv_source,
  input wire logic conv_launch,
  input wire logic conv_done,
  input wire logic irq_n
);
  // ==========================================================
  // Shadow of mask and conversion in flight
  logic [7:0] mask_q;
  logic busy_q;
  wire ctrl_wr = reg_wr && reg_addr == `REG_CONV_CTRL;
  always @(posedge mclk) begin
    if (!rstn) begin
      mask_q <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `REG_IRQ_MASK)
        mask_q <= reg_wdata;
      if (conv_launch)
        busy_q <= 1'b1;
      else if (conv_done || (ctrl_wr && !reg_wdata[2]))
        busy_q <= 1'b0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_launch_pulse: assert property (conv_launch |=> !conv_launch)
    else $error("launch longer than one cycle");
  a_launch_cause: assert property (conv_launch |->
    $past(ctrl_wr && reg_wdata[3] && converter_on))
    else $error("launch without start write");
  a_launch_idle: assert property (conv_launch |-> !busy_q)
    else $error("launch while busy");
  a_launch_on: assert property (conv_launch |-> converter_on)
    else $error("launch while off");
  a_ctrl_follow: assert property (ctrl_wr |=>
    {converter_on, conv_source} == $past(reg_wdata[2:0]))
    else $error("control outputs not written");
  a_done_irq: assert property (busy_q && conv_done && mask_q[4] |=> ##1 !irq_n)
    else $error("no request after done");
  a_mask_off: assert property (mask_q == 8'h00 |=> irq_n)
    else $error("request while all masked");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_ctrl_resv: assert property (reg_rd && reg_addr == `REG_CONV_CTRL |=>
    reg_rdata[7:6] == 2'b00)
    else $error("reserved bits set");
endmodule
bind mfp_ctrl mfp_ctrl_checker chk (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .converter_on(converter_on), .conv_source(conv_source), .conv_launch(conv_launch),
  .conv_done(conv_done), .irq_n(irq_n));
`default_nettype wire

/* tb/conv_model.sv */
/*
  Converter model: answers a launch dly plus one cycles later with base plus source.
  Assumes conv_launch is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module conv_model (
  input wire logic mclk,
  input wire logic conv_launch,
  input wire logic [1:0] conv_source,
  input wire logic [7:0] base,
  input wire logic ovr,
  input wire logic [7:0] dly,
  output logic conv_done,
  output logic conv_over_range,
  output logic [7:0] conv_data
);
  int n = -1;
  logic [7:0] res = 8'h00;
  initial begin
    conv_done = 1'b0;
    conv_over_range = 1'b0;
    conv_data = 8'h00;
  end
  // Outside the done pulse the result lines flip so stale values never match
  always @(posedge mclk) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    conv_over_range <= ~conv_over_range;
    if (conv_launch) begin
      n <= int'(dly);
      res <= base + {6'h00, conv_source};
    end else if (n == 0) begin
      conv_done <= 1'b1;
      conv_data <= res;
      conv_over_range <= ovr;
      n <= -1;
    end else if (n > 0) begin
      n <= n - 1;
    end
  end
endmodule
`default_nettype wire

/* tb/mfp_ctrl_tb_top.sv */
/*
  Testbench for mfp_ctrl: registers, sources, conversions, comparators.
  Assumes SLOW_CYCLES of 20, so a 2 ms interval is 40 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfp_consts.vh"
module mfp_ctrl_tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] crossing_direction = 4'h1;
  logic [3:0] multi_function_pin = 4'h2;
  logic output_undervolt = 1'b0;
  logic unknown_command = 1'b0;
  logic link_parity_error = 1'b0;
  logic converter_on, conv_launch, conv_done, conv_over_range, irq_n;
  logic [1:0] conv_source;
  logic [7:0] reg_rdata, conv_data, rv;
  logic [7:0] base = 8'h40;
  logic ovr = 1'b0;
  logic [7:0] dly = 8'h14;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  mfp_ctrl #(.SLOW_CYCLES(20)) uut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .crossing_direction(crossing_direction), .multi_function_pin(multi_function_pin),
    .output_undervolt(output_undervolt), .unknown_command(unknown_command),
    .link_parity_error(link_parity_error), .converter_on(converter_on),
    .conv_source(conv_source), .conv_launch(conv_launch), .conv_done(conv_done),
    .conv_over_range(conv_over_range), .conv_data(conv_data), .irq_n(irq_n));
  conv_model far (.mclk(mclk), .conv_launch(conv_launch), .conv_source(conv_source),
    .base(base), .ovr(ovr), .dly(dly), .conv_done(conv_done),
    .conv_over_range(conv_over_range), .conv_data(conv_data));
  initial begin
    forever #50 mclk = ~mclk;
  end
  // ==========================================================
  // Helpers
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [4:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    rv = reg_rdata;
  endtask
  task automatic wait_irq(input logic lvl, input int n);
    repeat (n) begin
      @(negedge mclk);
      if (irq_n === lvl)
        break;
    end
    @(posedge mclk);
    chk({7'h00, irq_n}, {7'h00, lvl});
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    for (int a = 11; a <= 16; a++) begin
      rd(a[4:0]);
      chk(rv, 8'h00);
    end
    wr(`REG_IRQ_MASK, 8'ha5);
    wr(`REG_CONV_RESULT, 8'h5a);
    wr(`REG_IRQ_REQUEST, 8'hff);
    wr(`REG_CMP_ENABLE, 8'hf0);
    rd(`REG_IRQ_MASK);
    chk(rv, 8'ha5);
    rd(`REG_CONV_RESULT);
    chk(rv, 8'h00);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h00);
    rd(`REG_CMP_ENABLE);
    chk(rv, 8'hf0);
    rd(5'h1f);
    chk(rv, 8'h00);
  endtask
  task automatic t_sources();
    wr(`REG_IRQ_MASK, 8'he0);
    unknown_command <= 1'b1;
    link_parity_error <= 1'b1;
    output_undervolt <= 1'b1;
    waitc(1);
    unknown_command <= 1'b0;
    link_parity_error <= 1'b0;
    waitc(5);
    output_undervolt <= 1'b0;
    wait_irq(1'b0, 8);
    waitc(4);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'he0);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h00);
    wait_irq(1'b1, 4);
  endtask
  task automatic t_conv();
    wr(`REG_IRQ_MASK, 8'h10);
    wr(`REG_CONV_CTRL, 8'h06);
    wr(`REG_CONV_CTRL, 8'h0e);
    wait_irq(1'b0, 60);
    rd(`REG_CONV_RESULT);
    chk(rv, 8'h42);
    rd(`REG_CONV_CTRL);
    chk(rv, 8'h1e);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h10);
    wr(`REG_CONV_CTRL, 8'h0e);
    waitc(40);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h00);
    wr(`REG_IRQ_MASK, 8'h00);
    base <= 8'hf0;
    ovr <= 1'b1;
    dly <= 8'h01;
    wr(`REG_CONV_CTRL, 8'h07);
    wr(`REG_CONV_CTRL, 8'h0f);
    waitc(10);
    chk({7'h00, irq_n}, 8'h01);
    rd(`REG_CONV_CTRL);
    chk(rv, 8'h3f);
    rd(`REG_CONV_RESULT);
    chk(rv, 8'hf3);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h10);
    ovr <= 1'b0;
    dly <= 8'h14;
    wr(`REG_CONV_CTRL, 8'h07);
    wr(`REG_CONV_CTRL, 8'h0f);
    waitc(3);
    rd(`REG_CONV_CTRL);
    chk(rv, 8'h0f);
    wr(`REG_CONV_CTRL, 8'h0b);
    waitc(40);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h00);
  endtask
  task automatic t_cmp();
    wr(`REG_IRQ_MASK, 8'h0f);
    wr(`REG_CMP_INTERVAL, 8'h04);
    wr(`REG_CMP_ENABLE, 8'h01);
    waitc(30);
    multi_function_pin[0] <= 1'b1;
    waitc(20);
    multi_function_pin[0] <= 1'b0;
    waitc(60);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h00);
    multi_function_pin[0] <= 1'b1;
    wait_irq(1'b0, 80);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h01);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h01);
    wr(`REG_CMP_ENABLE, 8'h00);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h00);
    wr(`REG_CMP_ENABLE, 8'h01);
    waitc(30);
    multi_function_pin[0] <= 1'b0;
    waitc(80);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h00);
    wr(`REG_CMP_ENABLE, 8'h22);
    waitc(100);
    multi_function_pin[1] <= 1'b0;
    waitc(100);
    chk({7'h00, irq_n}, 8'h01);
    wait_irq(1'b0, 400);
    rd(`REG_IRQ_REQUEST);
    chk(rv, 8'h02);
  endtask
  initial begin
    waitc(2);
    rstn <= 1'b1;
    waitc(1);
    t_regs();
    t_sources();
    t_conv();
    t_cmp();
    report_and_stop();
  end
endmodule
`default_nettype wire
